// *** include/wavegen_regs.svh ***
// Purpose: Register offsets, field positions and reset values of the waveform generator.
// Assumes: Byte addresses on a 32-bit Wishbone bus, one aligned word per register.
// Notes: Definitions only; included by bare name.
`ifndef WAVEGEN_REGS_SVH
`define WAVEGEN_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CONTROL0 8'h00
`define OFS_RISE_DB 8'h04
`define OFS_FALL_DB 8'h08
`define OFS_SD_CONTROL0 8'h0C
`define OFS_SD_SOURCE 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_STATUS 8'h1C

// ****************************************
// Field positions
// ****************************************
`define CTL_EN 0
`define CTL_LOAD 1
`define CTL_FULL 2
`define CTL_REV 3
`define CTL_HFOSC 4
`define SD_BIT 0
`define SD_AUTORESTART 1
`define SD_ENABLE 2
`define SD_OVR_LSB 4
`define SRC_COMP1 0
`define SRC_COMP2 1
`define SRC_TIMER2 2
`define SRC_PIN 3
`define IRQ_SHUTDOWN 0
`define IRQ_LOADED 1
`define IRQ_RESTART 2
`define STAT_SHUTDOWN 0
`define STAT_INPUT 1
`define STAT_RISE_LSB 8
`define STAT_FALL_LSB 16

// ****************************************
// Reset values
// ****************************************
`define RST_CONTROL0 8'h00
`define RST_DB 6'h00
`define RST_SD_CONTROL0 8'h00
`define RST_SD_SOURCE 4'h0
`define RST_IRQ 3'h0

`endif

// *** include/wavegen_pkg.sv ***
// Purpose: Shared types of the waveform generator.
// Assumes: Used as wavegen_pkg::name, never imported.
// Notes: Types only; numbers live in wavegen_regs.svh.
package wavegen_pkg;
	// Generator operating state
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SHUTDOWN} gen_state_t;
	// Bridge steering direction
	typedef enum logic {DIR_FORWARD, DIR_REVERSE} direction_t;
endpackage

// *** design/deadband_counter.sv ***
// Purpose: One dead-band timer counting generator clocks from zero up to a limit.
// Assumes: start and cancel are one-cycle pulses; cancel wins over start.
// Notes: done stays high after the count completes until the next start or cancel.
`timescale 1ns/10ps
module deadband_counter #(
	parameter int WIDTH = 6
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic start,
	input wire logic cancel,
	input wire logic [WIDTH-1:0] limit,
	output logic done
);
	logic [WIDTH-1:0] cnt_reg;
	logic active_reg;

	// ****************************************
	// Counter
	// ****************************************
	// Count restarts from zero on start; a cancel leaves the output inactive
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			if (cancel) begin
				active_reg <= 1'b0;
				done <= 1'b0;
			end else if (start) begin
				cnt_reg <= '0;
				active_reg <= (limit != '0);
				done <= (limit == '0);
			end else if (active_reg) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (cnt_reg + 1'b1 == limit) begin
					active_reg <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// *** design/waveform_deadband_shutdown.sv ***
// Purpose: Complementary waveform generator with dead-band timing and auto-shutdown.
// Assumes: All inputs synchronous to clk; Wishbone classic slave with 32-bit data.
// Notes: Outputs and ack come from flops, so each lags its cause by one clock; irq lags its event by two.
`timescale 1ns/10ps
`include "wavegen_regs.svh"
module waveform_deadband_shutdown #(
	parameter int DB_WIDTH = 6
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mod_in,
	input wire logic comparator1_sync_out,
	input wire logic comparator2_sync_out,
	input wire logic timer2_postscaled_out,
	input wire logic waveform_input_pin,
	input wire logic sleep_mode,
	input wire logic input_source_active,
	output logic out_a,
	output logic out_b,
	output logic out_c,
	output logic out_d,
	output logic high_freq_internal_osc_hold,
	output logic irq
);
	// ****************************************
	// Declarations
	// ****************************************
	logic bus_req, wr, rd;
	logic en_reg, load_reg, full_reg, rev_reg, hfosc_reg;
	logic [DB_WIDTH-1:0] rise_db_reg, fall_db_reg, rise_work_reg, fall_work_reg;
	logic sd_reg, sd_next, autorestart_reg, sd_enable_reg;
	logic [3:0] ovr_reg, src_sel_reg, src_low;
	logic src_active;
	logic [2:0] irq_status_reg, irq_mask_reg, irq_event;
	logic in_prev_reg, in_rise, in_fall, en_prev_reg, en_rise;
	logic xfer, dir_switch;
	wavegen_pkg::direction_t dir_reg;
	wavegen_pkg::gen_state_t state_reg, state_next;
	logic rise_start, rise_cancel, fall_start, fall_cancel, rise_done, fall_done;
	logic norm_a, norm_b, norm_c, norm_d;
	logic [31:0] rd_mux;

	// ****************************************
	// Wishbone slave
	// ****************************************
	// One request per handshake; ack drops in the cycle after it was given
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = bus_req & wb_we_i & wb_sel_i[0];
	assign rd = bus_req & ~wb_we_i;

	// Read data is latched with ack; unmapped offsets answer zero
	always_comb begin
		rd_mux = 32'h00000000;
		case (wb_adr_i)
			`OFS_CONTROL0: rd_mux[4:0] = {hfosc_reg, rev_reg, full_reg, load_reg, en_reg};
			`OFS_RISE_DB: rd_mux[DB_WIDTH-1:0] = rise_db_reg;
			`OFS_FALL_DB: rd_mux[DB_WIDTH-1:0] = fall_db_reg;
			`OFS_SD_CONTROL0: rd_mux[7:0] = {ovr_reg, 1'b0, sd_enable_reg, autorestart_reg, sd_reg};
			`OFS_SD_SOURCE: rd_mux[3:0] = src_sel_reg;
			`OFS_IRQ_STATUS: rd_mux[2:0] = irq_status_reg;
			`OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
			`OFS_STATUS: begin
				rd_mux[`STAT_SHUTDOWN] = (state_reg == wavegen_pkg::ST_SHUTDOWN);
				rd_mux[`STAT_INPUT] = mod_in;
				rd_mux[`STAT_RISE_LSB +: DB_WIDTH] = rise_work_reg;
				rd_mux[`STAT_FALL_LSB +: DB_WIDTH] = fall_work_reg;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= bus_req;
			if (rd) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// ****************************************
	// Input edges
	// ****************************************
	assign in_rise = mod_in & ~in_prev_reg;
	assign in_fall = ~mod_in & in_prev_reg;
	assign en_rise = en_reg & ~en_prev_reg;

	// Generator runs on clk and ce alone; sleep_mode does not gate it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_prev_reg <= 1'b0;
			en_prev_reg <= 1'b0;
		end else if (ce) begin
			in_prev_reg <= mod_in;
			en_prev_reg <= en_reg;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	assign xfer = en_reg & load_reg & in_fall;

	// A software write of the load bit in the transfer cycle wins over the self-clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{hfosc_reg, rev_reg, full_reg, load_reg, en_reg} <= 5'(`RST_CONTROL0);
		end else if (ce) begin
			if (xfer) begin
				load_reg <= 1'b0;
			end
			if (wr && wb_adr_i == `OFS_CONTROL0) begin
				en_reg <= wb_dat_i[`CTL_EN];
				load_reg <= wb_dat_i[`CTL_LOAD];
				full_reg <= wb_dat_i[`CTL_FULL];
				rev_reg <= wb_dat_i[`CTL_REV];
				hfosc_reg <= wb_dat_i[`CTL_HFOSC];
			end
		end
	end

	// ****************************************
	// Dead-band settings, double-buffered
	// ****************************************
	// Disabled: write goes straight through; enabled: waits for load at falling edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rise_db_reg <= `RST_DB;
			fall_db_reg <= `RST_DB;
			rise_work_reg <= `RST_DB;
			fall_work_reg <= `RST_DB;
		end else if (ce) begin
			if (xfer) begin
				rise_work_reg <= rise_db_reg;
				fall_work_reg <= fall_db_reg;
			end
			if (wr && wb_adr_i == `OFS_RISE_DB) begin
				rise_db_reg <= wb_dat_i[DB_WIDTH-1:0];
				if (!en_reg) begin
					rise_work_reg <= wb_dat_i[DB_WIDTH-1:0];
				end
			end
			if (wr && wb_adr_i == `OFS_FALL_DB) begin
				fall_db_reg <= wb_dat_i[DB_WIDTH-1:0];
				if (!en_reg) begin
					fall_work_reg <= wb_dat_i[DB_WIDTH-1:0];
				end
			end
		end
	end

	// ****************************************
	// Shutdown configuration
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{ovr_reg, sd_enable_reg, autorestart_reg} <= 6'h00;
			src_sel_reg <= `RST_SD_SOURCE;
		end else if (ce) begin
			if (wr && wb_adr_i == `OFS_SD_CONTROL0) begin
				autorestart_reg <= wb_dat_i[`SD_AUTORESTART];
				sd_enable_reg <= wb_dat_i[`SD_ENABLE];
				ovr_reg <= wb_dat_i[`SD_OVR_LSB +: 4];
			end
			if (wr && wb_adr_i == `OFS_SD_SOURCE) begin
				src_sel_reg <= wb_dat_i[3:0];
			end
		end
	end

	// Sources are low-active levels, never edges
	assign src_low[`SRC_COMP1] = ~comparator1_sync_out;
	assign src_low[`SRC_COMP2] = ~comparator2_sync_out;
	assign src_low[`SRC_TIMER2] = ~timer2_postscaled_out;
	assign src_low[`SRC_PIN] = ~waveform_input_pin;
	assign src_active = sd_enable_reg & |(src_low & src_sel_reg);

	// Shutdown bit: software sets or clears, auto-restart clears, a source holds it set
	always_comb begin
		sd_next = sd_reg;
		if (sd_reg && autorestart_reg && in_rise) begin
			sd_next = 1'b0;
		end
		if (wr && wb_adr_i == `OFS_SD_CONTROL0) begin
			sd_next = wb_dat_i[`SD_BIT];
		end
		if (src_active) begin
			sd_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sd_reg <= 1'b0;
		end else if (ce) begin
			sd_reg <= sd_next;
		end
	end

	// ****************************************
	// Generator state
	// ****************************************
	// Next state follows sd_next so the override lands one clock after its cause
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			wavegen_pkg::ST_IDLE: begin
				if (en_reg) begin
					state_next = sd_next ? wavegen_pkg::ST_SHUTDOWN : wavegen_pkg::ST_RUN;
				end
			end
			wavegen_pkg::ST_RUN: begin
				if (!en_reg) begin
					state_next = wavegen_pkg::ST_IDLE;
				end else if (sd_next) begin
					state_next = wavegen_pkg::ST_SHUTDOWN;
				end
			end
			wavegen_pkg::ST_SHUTDOWN: begin
				if (!en_reg) begin
					state_next = wavegen_pkg::ST_IDLE;
				end else if (!sd_next) begin
					state_next = wavegen_pkg::ST_RUN;
				end
			end
			default: state_next = wavegen_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= wavegen_pkg::ST_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Direction and dead-band counters
	// ****************************************
	// Direction is applied at the first rising input edge after it was changed
	assign dir_switch = full_reg & en_reg & in_rise & (rev_reg != dir_reg);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dir_reg <= wavegen_pkg::DIR_FORWARD;
		end else if (ce) begin
			if (dir_switch || en_rise) begin
				dir_reg <= rev_reg ? wavegen_pkg::DIR_REVERSE : wavegen_pkg::DIR_FORWARD;
			end
		end
	end

	// Half bridge times each input edge; full bridge times only enable and a direction change
	always_comb begin
		if (!full_reg) begin
			rise_start = in_rise;
			fall_start = in_fall;
			rise_cancel = in_fall | ~en_reg;
			fall_cancel = in_rise | ~en_reg;
		end else begin
			rise_start = (dir_switch | en_rise) & rev_reg;
			fall_start = (dir_switch | en_rise) & ~rev_reg;
			rise_cancel = ~en_reg | (dir_switch & ~rev_reg);
			fall_cancel = ~en_reg | (dir_switch & rev_reg);
		end
	end

	// Two six-bit counters counting generator clocks up to the working values
	deadband_counter #(.WIDTH(DB_WIDTH)) rise_counter (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.start(rise_start),
		.cancel(rise_cancel),
		.limit(rise_work_reg),
		.done(rise_done)
	);

	deadband_counter #(.WIDTH(DB_WIDTH)) fall_counter (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.start(fall_start),
		.cancel(fall_cancel),
		.limit(fall_work_reg),
		.done(fall_done)
	);

	// ****************************************
	// Output stage
	// ****************************************
	// In half bridge an output only rises once its count completed while the input held its level; full bridge holds A or C on
	always_comb begin
		if (!full_reg) begin
			norm_a = mod_in & rise_done;
			norm_b = ~mod_in & fall_done;
			norm_c = norm_a;
			norm_d = norm_b;
		end else if (dir_reg == wavegen_pkg::DIR_FORWARD) begin
			norm_a = 1'b1;
			norm_b = 1'b0;
			norm_c = 1'b0;
			norm_d = mod_in & fall_done;
		end else begin
			norm_a = 1'b0;
			norm_b = mod_in & rise_done;
			norm_c = 1'b1;
			norm_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{out_d, out_c, out_b, out_a} <= 4'h0;
		end else if (ce) begin
			case (state_next)
				wavegen_pkg::ST_RUN: {out_d, out_c, out_b, out_a} <= {norm_d, norm_c, norm_b, norm_a};
				wavegen_pkg::ST_SHUTDOWN: {out_d, out_c, out_b, out_a} <= ovr_reg;
				default: {out_d, out_c, out_b, out_a} <= 4'h0;
			endcase
		end
	end

	// Oscillator must stay up in sleep only while the generator needs it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			high_freq_internal_osc_hold <= 1'b0;
		end else if (ce) begin
			high_freq_internal_osc_hold <= en_reg & input_source_active & hfosc_reg & sleep_mode;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign irq_event[`IRQ_SHUTDOWN] = (state_next == wavegen_pkg::ST_SHUTDOWN) &&
		(state_reg != wavegen_pkg::ST_SHUTDOWN);
	assign irq_event[`IRQ_LOADED] = xfer;
	assign irq_event[`IRQ_RESTART] = (state_reg == wavegen_pkg::ST_SHUTDOWN) &&
		(state_next == wavegen_pkg::ST_RUN);

	// Read clears the status; an event in the same cycle survives the clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_status_reg <= `RST_IRQ;
			irq_mask_reg <= `RST_IRQ;
			irq <= 1'b0;
		end else if (ce) begin
			if (rd && wb_adr_i == `OFS_IRQ_STATUS) begin
				irq_status_reg <= irq_event;
			end else begin
				irq_status_reg <= irq_status_reg | irq_event;
			end
			if (wr && wb_adr_i == `OFS_IRQ_MASK) begin
				irq_mask_reg <= wb_dat_i[2:0];
			end
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end
endmodule

// *** dv/wavegen_monitor.sv ***
// Purpose: Port-level checks of the waveform generator.
// Assumes: Field layout of wavegen_regs.svh; one clock domain.
// Notes: Shadows follow software writes only, never hardware updates.
`timescale 1ns/10ps
`include "wavegen_regs.svh"
module wavegen_monitor #(
	parameter int DB_WIDTH = 6
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic comparator1_sync_out,
	input wire logic comparator2_sync_out,
	input wire logic timer2_postscaled_out,
	input wire logic waveform_input_pin,
	input wire logic sleep_mode,
	input wire logic input_source_active,
	input wire logic out_a,
	input wire logic out_b,
	input wire logic out_c,
	input wire logic out_d,
	input wire logic high_freq_internal_osc_hold,
	input wire logic irq
);
	// ****
	// Software shadows
	// ****
	logic en_q, hf_q, ae_q, wr_take, rd_take;
	logic [3:0] ovr_q, src_q, outs, act;
	logic [2:0] mask_q;
	// A write lands at the edge that takes it, as in the slave
	assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & ce & wb_sel_i[0];
	assign rd_take = wb_cyc_i & wb_stb_i & !wb_we_i & !wb_ack_o & ce;
	assign outs = {out_d, out_c, out_b, out_a};
	assign act = ~{waveform_input_pin, timer2_postscaled_out, comparator2_sync_out, comparator1_sync_out} & src_q;
	// Capture enable, oscillator select, shutdown fields and mask
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_q <= 1'b0;
			hf_q <= 1'b0;
			ae_q <= 1'b0;
			ovr_q <= 4'h0;
			src_q <= 4'h0;
			mask_q <= 3'h0;
		end else if (wr_take) begin
			case (wb_adr_i)
				`OFS_CONTROL0: begin
					en_q <= wb_dat_i[`CTL_EN];
					hf_q <= wb_dat_i[`CTL_HFOSC];
				end
				`OFS_SD_CONTROL0: begin
					ae_q <= wb_dat_i[`SD_ENABLE];
					ovr_q <= wb_dat_i[`SD_OVR_LSB +: 4];
				end
				`OFS_SD_SOURCE: src_q <= wb_dat_i[3:0];
				`OFS_IRQ_MASK: mask_q <= wb_dat_i[2:0];
				default: ;
			endcase
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	endsequence
	sequence s_fault;
		en_q && ae_q && act != 4'h0 && ce;
	endsequence
	sequence s_sw_sd;
		en_q && wr_take && wb_adr_i == `OFS_SD_CONTROL0 && wb_dat_i[`SD_BIT];
	endsequence
	property p_ack_next;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_pulse;
		wb_ack_o && ce |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_rd_stable;
		!rd_take |=> $stable(wb_dat_o);
	endproperty
	a_rd_stable: assert property (p_rd_stable) else $error("read data moved without a read");
	property p_src_override;
		s_fault |=> outs == ovr_q;
	endproperty
	a_src_override: assert property (p_src_override) else $error("fault not overriding");
	property p_sw_override;
		s_sw_sd |-> ##[1:2] outs == ovr_q;
	endproperty
	a_sw_override: assert property (p_sw_override) else $error("software shutdown not seen");
	property p_osc_hold;
		ce |=> high_freq_internal_osc_hold == $past(en_q && input_source_active && hf_q && sleep_mode);
	endproperty
	a_osc_hold: assert property (p_osc_hold) else $error("oscillator hold wrong");
	property p_irq_mask;
		mask_q == 3'h0 ##1 mask_q == 3'h0 |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while fully masked");
	property p_ce_freeze;
		!ce |=> $stable({outs, wb_ack_o, irq});
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");
	property p_idle_off;
		!en_q ##1 !en_q |-> outs == 4'h0;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("outputs active while disabled");
endmodule
bind waveform_deadband_shutdown wavegen_monitor #(.DB_WIDTH(DB_WIDTH)) mon_u (.clk(clk), .rstn(rstn), .ce(ce),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator1_sync_out(comparator1_sync_out),
	.comparator2_sync_out(comparator2_sync_out), .timer2_postscaled_out(timer2_postscaled_out),
	.waveform_input_pin(waveform_input_pin), .sleep_mode(sleep_mode), .input_source_active(input_source_active),
	.out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
	.high_freq_internal_osc_hold(high_freq_internal_osc_hold), .irq(irq));

// *** dv/bridge_partner.sv ***
// Purpose: Far side: modulating source and fault lines.
// Assumes: Phase lengths in clk cycles, at least 1.
// Notes: Faults are asked for active high, driven active low.
`timescale 1ns/10ps
module bridge_partner (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [7:0] hi_len,
	input wire logic [7:0] lo_len,
	input wire logic [3:0] fault,
	output logic mod_in,
	output logic comparator1_sync_out,
	output logic comparator2_sync_out,
	output logic timer2_postscaled_out,
	output logic waveform_input_pin
);
	logic [7:0] cnt;
	// Tripped sources pull their lines low
	assign {waveform_input_pin, timer2_postscaled_out, comparator2_sync_out, comparator1_sync_out} = ~fault;
	// Square wave; idles low when stopped so no stray edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 8'h01;
			mod_in <= 1'b0;
		end else if (!run) begin
			cnt <= 8'h01;
			mod_in <= 1'b0;
		end else if (cnt >= (mod_in ? hi_len : lo_len)) begin
			mod_in <= !mod_in;
			cnt <= 8'h01;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// *** dv/tb_waveform_deadband_shutdown.sv ***
// Purpose: Self-checking bench of the waveform generator.
// Assumes: Half bridge, forward, until the last test; register map of wavegen_regs.svh.
// Notes: Dead bands compared as differences so fixed lag cancels.
`timescale 1ns/10ps
`include "wavegen_regs.svh"
module tb_waveform_deadband_shutdown;
	logic clk, rstn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mod_in, c1, c2, t2, pin;
	logic sleep_mode, isa, run, out_a, out_b, out_c, out_d, hold, irq, seen;
	logic [7:0] wb_adr_i, hi_len, lo_len;
	logic [3:0] wb_sel_i, fault, outs;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	int error_cnt, num_checks, tcnt, d2, d5, k;
	assign outs = {out_d, out_c, out_b, out_a};
	waveform_deadband_shutdown #(.DB_WIDTH(6)) dut_u (.clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_in(mod_in), .comparator1_sync_out(c1),
		.comparator2_sync_out(c2), .timer2_postscaled_out(t2), .waveform_input_pin(pin), .sleep_mode(sleep_mode),
		.input_source_active(isa), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
		.high_freq_internal_osc_hold(hold), .irq(irq));
	bridge_partner partner_u (.clk(clk), .rstn(rstn), .run(run), .hi_len(hi_len), .lo_len(lo_len), .fault(fault),
		.mod_in(mod_in), .comparator1_sync_out(c1), .comparator2_sync_out(c2), .timer2_postscaled_out(t2),
		.waveform_input_pin(pin));
	// ****
	// Tasks
	// ****
	// Classic cycle: hold until ack, then idle one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		// No cycle count assumed; a missing ack is caught by the watchdog
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h00000000, 4'hF);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wait_mod(input logic v);
		int n;
		n = 0;
		while (mod_in !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Edges from a falling input edge to B turning on
	task automatic meas(output int d);
		wait_mod(1'b1);
		wait_mod(1'b0);
		d = 0;
		while (out_b !== 1'b1 && d < 60) begin
			@(posedge clk);
			d++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ****
	// Clock and watchdog
	// ****
	// 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// A hang ends the run as a failure
	always @(posedge clk) begin
		tcnt++;
		if (tcnt == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ****
	// Tests
	// ****
	initial begin
		{rstn, wb_cyc_i, wb_stb_i, wb_we_i, sleep_mode, isa, run} = 7'h00;
		{ce, wb_adr_i, wb_sel_i, wb_dat_i, fault, hi_len, lo_len} = {1'b1, 48'h0, 8'h14, 8'h14};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(`OFS_CONTROL0);
		chk(r, 32'h00000000);
		wb(1'b1, `OFS_FALL_DB, 32'h3, 4'hE);
		rd(`OFS_FALL_DB);
		chk(r, 32'h00000000);
		rd(8'h20);
		chk(r, 32'h00000000);
		$display("test registers done");
		wr(`OFS_FALL_DB, 32'h2);
		rd(`OFS_STATUS);
		chk(32'(r[21:16]), 32'h2);
		run <= 1'b1;
		wr(`OFS_CONTROL0, 32'h1);
		meas(d2);
		wr(`OFS_FALL_DB, 32'h5);
		wr(`OFS_CONTROL0, 32'h3);
		rd(`OFS_STATUS);
		chk(32'(r[21:16]), 32'h2);
		meas(k);
		rd(`OFS_CONTROL0);
		chk(r, 32'h1);
		rd(`OFS_STATUS);
		chk(32'(r[21:16]), 32'h5);
		meas(d5);
		chk(d5 - d2, 3);
		// Low phase shorter than the dead band keeps B off
		lo_len <= 8'h03;
		repeat (5) @(posedge clk);
		seen = 1'b0;
		repeat (90) begin
			@(posedge clk);
			seen = seen | out_b;
		end
		chk(32'(seen), 32'h0);
		lo_len <= 8'h14;
		$display("test dead band done");
		wr(`OFS_CONTROL0, 32'h11);
		sleep_mode <= 1'b1;
		isa <= 1'b1;
		ce <= 1'b0;
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		k = 0;
		repeat (60) begin
			@(posedge clk);
			k += (out_a === 1'b1);
		end
		chk(32'(k > 0 && k < 60), 32'h1);
		chk(32'(hold), 32'h1);
		isa <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(hold), 32'h0);
		sleep_mode <= 1'b0;
		$display("test sleep done");
		// Each source alone, with all others tripped but unselected
		for (k = 0; k < 4; k++) begin
			wr(`OFS_SD_SOURCE, 32'(1 << k));
			wr(`OFS_SD_CONTROL0, 32'h64);
			fault <= ~(4'h1 << k);
			repeat (4) @(posedge clk);
			rd(`OFS_STATUS);
			chk(32'(r[0]), 32'h0);
			fault <= 4'h1 << k;
			repeat (3) @(posedge clk);
			chk(32'(outs), 32'h6);
			wr(`OFS_SD_CONTROL0, 32'h64);
			chk(32'(outs), 32'h6);
			fault <= 4'h0;
			repeat (3) @(posedge clk);
			chk(32'(outs), 32'h6);
			wr(`OFS_SD_CONTROL0, 32'h64);
			repeat (3) @(posedge clk);
			rd(`OFS_STATUS);
			chk(32'(r[0]), 32'h0);
		end
		wr(`OFS_SD_CONTROL0, 32'h65);
		repeat (20) @(posedge clk);
		chk(32'(outs), 32'h6);
		wr(`OFS_SD_CONTROL0, 32'h67);
		wait_mod(1'b0);
		wait_mod(1'b1);
		repeat (3) @(posedge clk);
		rd(`OFS_SD_CONTROL0);
		chk(r, 32'h66);
		chk(32'(outs == 4'h6), 32'h0);
		$display("test shutdown done");
		wr(`OFS_SD_CONTROL0, 32'h64);
		wr(`OFS_SD_SOURCE, 32'h1);
		rd(`OFS_IRQ_STATUS);
		wr(`OFS_IRQ_MASK, 32'h1);
		fault <= 4'h1;
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h1);
		fault <= 4'h0;
		wr(`OFS_SD_CONTROL0, 32'h64);
		rd(`OFS_IRQ_STATUS);
		chk(32'(r[0]), 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		$display("test interrupt done");
		// Full bridge forward: A held on, D follows the input once the falling dead band ran out
		wr(`OFS_CONTROL0, 32'h0);
		wr(`OFS_CONTROL0, 32'h5);
		wait_mod(1'b0);
		wait_mod(1'b1);
		repeat (8) @(posedge clk);
		chk(32'(outs), 32'h9);
		$display("test full bridge done");
		report_and_stop();
	end
endmodule
